// [pmc_regs.vh]
`ifndef PMC_REGS_VH
`define PMC_REGS_VH
// Data-space offsets of the registers.
`define PMC_SLEEP_CTRL_ADDR 8'h53
`define PMC_CORE_ADDR      8'h55
`define PMC_PWR_RED_ADDR   8'h64
// Offset between data-space and I/O-space addresses.
`define PMC_IO_BASE        8'h20
// Highest I/O-space address.
`define PMC_IO_TOP         6'h3F
// Reset value of every register.
`define PMC_RESET_VAL      8'h00
// Sleep mode control fields.
`define PMC_SLEEP_EN_BIT   0
`define PMC_MODE_LSB       1
`define PMC_MODE_MSB       3
// Core control fields.
`define PMC_DBGDIS_BIT     7
`define PMC_BOD_OFF_BIT    6
`define PMC_BOD_OFF_EN_BIT 5
`define PMC_PULL_DIS_BIT   4
`define PMC_VEC_SEL_BIT    1
`define PMC_VEC_CHG_BIT    0
// Core control bits that exist; bits 3 and 2 read as zero.
`define PMC_CORE_MASK      8'hF3
// Power reduction bits.
`define PMC_GATE_TWO_WIRE  7
`define PMC_GATE_TIMER2    6
`define PMC_GATE_TIMER0    5
`define PMC_GATE_SERIAL1   4
`define PMC_GATE_TIMER1    3
`define PMC_GATE_SPI       2
`define PMC_GATE_SERIAL0   1
`define PMC_GATE_CONV      0
// Sleep mode encodings.
`define PMC_MODE_IDLE      3'h0
`define PMC_MODE_NOISE     3'h1
`define PMC_MODE_DOWN      3'h2
`define PMC_MODE_SAVE      3'h3
`define PMC_MODE_STBY      3'h6
`define PMC_MODE_XSTBY     3'h7
// Timed-write window and delays in cycles.
`define PMC_WINDOW_CYC     3'h4
`define PMC_BOD_OFF_DELAY  3'h3
`define PMC_BOD_OFF_HOLD   3'h3
`define PMC_WAKE_CYC       3'h6
`endif

// [pmc_timed_window.v]
`timescale 1ns/100ps
`include "pmc_regs.vh"
// Counts a timed-write window that opens on a start pulse and closes after a fixed count.
module pmc_timed_window #(
  parameter CYCLES = 3'h4
) (
  input  wire       sys_clk,
  input  wire       resetn,
  input  wire       clk_en,
  input  wire       start,
  input  wire       close,
  output wire       open
);
  reg  [2:0] count_reg;

  // Reloads on start, counts down each enabled cycle, and closes early on request.
  always @(posedge sys_clk) begin
    if (!resetn) begin
      count_reg <= 3'h0;
    end else if (clk_en) begin
      if (start) begin
        count_reg <= CYCLES;
      end else if (close) begin
        count_reg <= 3'h0;
      end else if (count_reg != 3'h0) begin
        count_reg <= count_reg - 3'h1;
      end
    end
  end

  assign open = (count_reg != 3'h0);
endmodule

// [pmc_wake_delay.v]
`timescale 1ns/100ps
`include "pmc_regs.vh"
// Counts the cycles from a wake-up condition until execution resumes.
module pmc_wake_delay #(
  parameter CYCLES = 3'h6
) (
  input  wire       sys_clk,
  input  wire       resetn,
  input  wire       clk_en,
  input  wire       start,
  output wire       busy,
  output reg        done
);
  reg  [2:0] count_reg;

  // Loads on start and pulses done as the count reaches zero.
  always @(posedge sys_clk) begin
    if (!resetn) begin
      count_reg <= 3'h0;
      done      <= 1'b0;
    end else if (clk_en) begin
      done <= 1'b0;
      if (start) begin
        count_reg <= CYCLES;
      end else if (count_reg != 3'h0) begin
        count_reg <= count_reg - 3'h1;
        if (count_reg == 3'h1) begin
          done <= 1'b1;
        end
      end
    end
  end

  assign busy = (count_reg != 3'h0);
endmodule

// [pmc_power_control.v]
`timescale 1ns/100ps
`include "pmc_regs.vh"
module pmc_power_control (
  sys_clk,
  resetn,
  clk_en,
  bus_addr,
  bus_io_space,
  bus_wr,
  bus_rd,
  bus_wdata,
  bus_rdata,
  bus_hit,
  sleep_instr,
  wake_request,
  core_sleeping,
  core_resume,
  sleep_mode_select,
  brownout_off,
  debug_port_fuse,
  debug_port_enable,
  pullup_disable,
  pullup_request,
  pullup_enable,
  vector_select,
  boot_size_fuse,
  vector_base,
  exec_in_boot,
  app_section_lock_bit,
  boot_section_lock_bit,
  irq_block,
  timer2_async_select,
  clock_stop,
  comparator_mux_ok
);
  parameter PINS = 32;
  parameter BOOT_W = 2;
  parameter VEC_W = 16;

  input  wire              sys_clk;
  input  wire              resetn;
  input  wire              clk_en;
  input  wire [7:0]        bus_addr;
  input  wire              bus_io_space;
  input  wire              bus_wr;
  input  wire              bus_rd;
  input  wire [7:0]        bus_wdata;
  output reg  [7:0]        bus_rdata;
  output wire              bus_hit;
  input  wire              sleep_instr;
  input  wire              wake_request;
  output reg               core_sleeping;
  output wire              core_resume;
  output wire [2:0]        sleep_mode_select;
  output reg               brownout_off;
  input  wire              debug_port_fuse;
  output wire              debug_port_enable;
  output wire              pullup_disable;
  input  wire [PINS-1:0]   pullup_request;
  output wire [PINS-1:0]   pullup_enable;
  output wire              vector_select;
  input  wire [BOOT_W-1:0] boot_size_fuse;
  output reg  [VEC_W-1:0]  vector_base;
  input  wire              exec_in_boot;
  input  wire              app_section_lock_bit;
  input  wire              boot_section_lock_bit;
  output wire              irq_block;
  input  wire              timer2_async_select;
  output wire [7:0]        clock_stop;
  output wire              comparator_mux_ok;

  // Pin-level straps pass two flip-flops before use.
  reg  [1:0]        fuse_sync_reg;
  reg  [1:0]        t2_async_sync_reg;
  reg  [1:0]        appl_sync_reg;
  reg  [1:0]        bootl_sync_reg;
  reg  [BOOT_W-1:0] bsz_meta_reg;
  reg  [BOOT_W-1:0] bsz_sync_reg;

  reg  [7:0]        sleep_ctrl_reg;
  reg  [7:0]        prr_reg;
  reg               dbgdis_reg;
  reg               dbg_val_reg;
  reg               bod_off_reg;
  reg               pull_dis_reg;
  reg               vec_sel_reg;
  reg               vec_chg_reg;
  reg               vec_follow_reg;
  reg  [2:0]        bod_off_cnt_reg;
  reg  [2:0]        bod_off_cnt_next;
  reg               standby_reg;

  wire [7:0]        io_addr;
  wire [7:0]        eff_addr;
  wire              sel_sleep;
  wire              sel_core;
  wire              sel_prr;
  wire              wr_core;
  wire              dbg_open;
  wire              bod_en_open;
  wire              vec_chg_open;
  wire              bod_off_active;
  wire              vec_write;
  wire              wake_busy;
  wire              wake_done;
  wire [7:0]        core_view;

  // Synchronisers for the straps and lock bits.
  always @(posedge sys_clk) begin
    if (!resetn) begin
      fuse_sync_reg  <= 2'h0;
      t2_async_sync_reg <= 2'h0;
      appl_sync_reg  <= 2'h0;
      bootl_sync_reg <= 2'h0;
      bsz_meta_reg   <= {BOOT_W{1'b0}};
      bsz_sync_reg   <= {BOOT_W{1'b0}};
    end else if (clk_en) begin
      fuse_sync_reg  <= {fuse_sync_reg[0], debug_port_fuse};
      t2_async_sync_reg <= {t2_async_sync_reg[0], timer2_async_select};
      appl_sync_reg  <= {appl_sync_reg[0], app_section_lock_bit};
      bootl_sync_reg <= {bootl_sync_reg[0], boot_section_lock_bit};
      bsz_meta_reg   <= boot_size_fuse;
      bsz_sync_reg   <= bsz_meta_reg;
    end
  end

  // I/O-space addresses are shifted up to data space; extended space is data-only.
  assign io_addr  = {2'h0, bus_addr[5:0]} + `PMC_IO_BASE;
  assign eff_addr = bus_io_space ? io_addr : bus_addr;
  assign sel_sleep = (eff_addr == `PMC_SLEEP_CTRL_ADDR);
  assign sel_core = (eff_addr == `PMC_CORE_ADDR);
  assign sel_prr  = !bus_io_space && (bus_addr == `PMC_PWR_RED_ADDR);
  assign bus_hit  = sel_sleep || sel_core || sel_prr;
  assign wr_core  = bus_wr && sel_core && clk_en;
  assign vec_write = wr_core && !bus_wdata[`PMC_VEC_CHG_BIT] && vec_chg_open;

  // Timed windows for the debug disable, brown-out sleep-off and vector change.
  pmc_timed_window #(.CYCLES(`PMC_WINDOW_CYC)) u_dbg_win (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .clk_en  (clk_en),
    .start   (wr_core && !dbg_open),
    .close   (wr_core && dbg_open),
    .open    (dbg_open)
  );
  pmc_timed_window #(.CYCLES(`PMC_WINDOW_CYC)) u_bod_win (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .clk_en  (clk_en),
    .start   (wr_core && bus_wdata[`PMC_BOD_OFF_BIT] && bus_wdata[`PMC_BOD_OFF_EN_BIT]),
    .close   (wr_core && !bus_wdata[`PMC_BOD_OFF_EN_BIT]),
    .open    (bod_en_open)
  );
  pmc_timed_window #(.CYCLES(`PMC_WINDOW_CYC)) u_vec_win (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .clk_en  (clk_en),
    .start   (wr_core && bus_wdata[`PMC_VEC_CHG_BIT]),
    .close   (vec_write),
    .open    (vec_chg_open)
  );

  // Plain register writes and the timed-write state of the core control register.
  always @(posedge sys_clk) begin
    if (!resetn) begin
      sleep_ctrl_reg <= `PMC_RESET_VAL;
      prr_reg        <= `PMC_RESET_VAL;
      dbgdis_reg     <= 1'b0;
      dbg_val_reg    <= 1'b0;
      pull_dis_reg   <= 1'b0;
      vec_sel_reg    <= 1'b0;
      vec_chg_reg    <= 1'b0;
      vec_follow_reg <= 1'b0;
    end else if (clk_en) begin
      if (bus_wr && sel_sleep) begin
        sleep_ctrl_reg <= {4'h0, bus_wdata[3:0]};
      end
      if (bus_wr && sel_prr) begin
        prr_reg <= bus_wdata;
      end
      vec_follow_reg <= vec_write;
      if (wr_core) begin
        pull_dis_reg <= bus_wdata[`PMC_PULL_DIS_BIT];
        // A matching second write inside the window commits the debug bit.
        if (dbg_open && dbg_val_reg == bus_wdata[`PMC_DBGDIS_BIT]) begin
          dbgdis_reg <= bus_wdata[`PMC_DBGDIS_BIT];
        end
        dbg_val_reg <= bus_wdata[`PMC_DBGDIS_BIT];
        if (vec_write) begin
          vec_sel_reg <= bus_wdata[`PMC_VEC_SEL_BIT];
        end
      end
      // Change enable mirrors the open window and drops on vector write.
      vec_chg_reg <= (wr_core && bus_wdata[`PMC_VEC_CHG_BIT]) ||
                     (vec_chg_open && !vec_write &&
                      !(wr_core && !bus_wdata[`PMC_VEC_CHG_BIT]));
    end
  end

  // Brown-out sleep-off: set by the second step, active after a delay, then auto-clear.
  always @* begin
    bod_off_cnt_next = bod_off_cnt_reg;
    if (wr_core && bod_en_open && bus_wdata[`PMC_BOD_OFF_BIT] &&
        !bus_wdata[`PMC_BOD_OFF_EN_BIT]) begin
      bod_off_cnt_next = `PMC_BOD_OFF_DELAY + `PMC_BOD_OFF_HOLD;
    end else if (bod_off_cnt_reg != 3'h0) begin
      bod_off_cnt_next = bod_off_cnt_reg - 3'h1;
    end
  end

  always @(posedge sys_clk) begin
    if (!resetn) begin
      bod_off_cnt_reg <= 3'h0;
      bod_off_reg     <= 1'b0;
    end else if (clk_en) begin
      bod_off_cnt_reg <= bod_off_cnt_next;
      bod_off_reg     <= (bod_off_cnt_next != 3'h0);
    end
  end
  assign bod_off_active = (bod_off_cnt_reg != 3'h0) &&
                          (bod_off_cnt_reg <= `PMC_BOD_OFF_HOLD);

  // Sleep entry, brown-out shutdown and the wake-up path.
  pmc_wake_delay #(.CYCLES(`PMC_WAKE_CYC)) u_wake (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .clk_en  (clk_en),
    .start   (core_sleeping && wake_request && standby_reg),
    .busy    (wake_busy),
    .done    (wake_done)
  );

  always @(posedge sys_clk) begin
    if (!resetn) begin
      core_sleeping  <= 1'b0;
      brownout_off   <= 1'b0;
      standby_reg    <= 1'b0;
    end else if (clk_en) begin
      if (!core_sleeping && sleep_instr && sleep_ctrl_reg[`PMC_SLEEP_EN_BIT]) begin
        core_sleeping  <= 1'b1;
        standby_reg    <= (sleep_mode_select == `PMC_MODE_STBY) ||
                          (sleep_mode_select == `PMC_MODE_XSTBY);
        brownout_off   <= bod_off_active;
      end else if (core_sleeping && wake_request && !standby_reg && !wake_busy) begin
        core_sleeping <= 1'b0;
        brownout_off  <= 1'b0;
      end else if (wake_done) begin
        core_sleeping <= 1'b0;
        brownout_off  <= 1'b0;
      end
    end
  end
  assign core_resume = wake_done;
  assign sleep_mode_select = sleep_ctrl_reg[`PMC_MODE_MSB:`PMC_MODE_LSB];

  // Vector base follows the select bit and the boot size straps.
  always @* begin
    vector_base = {VEC_W{1'b0}};
    if (vec_sel_reg) begin
      vector_base = {VEC_W{1'b1}} << (VEC_W - 4 + {{(32-BOOT_W){1'b0}}, bsz_sync_reg});
    end
  end

  // Interrupt blocking during the vector change and for locked sections.
  assign irq_block = vec_chg_open || vec_write || vec_follow_reg ||
                     (vec_sel_reg && !exec_in_boot && appl_sync_reg[1]) ||
                     (!vec_sel_reg && exec_in_boot && bootl_sync_reg[1]);

  // Static outputs from the register bits.
  assign debug_port_enable = fuse_sync_reg[1] && !dbgdis_reg;
  assign pullup_disable    = pull_dis_reg;
  assign pullup_enable     = pull_dis_reg ? {PINS{1'b0}} : pullup_request;
  assign vector_select     = vec_sel_reg;
  // Gated clocks hold module state; timer 2 gates only while synchronous.
  assign clock_stop = {prr_reg[`PMC_GATE_TWO_WIRE],
                       prr_reg[`PMC_GATE_TIMER2] && !t2_async_sync_reg[1],
                       prr_reg[5:0]};
  assign comparator_mux_ok = !prr_reg[`PMC_GATE_CONV];

  assign core_view = {dbgdis_reg, bod_off_reg, bod_en_open, pull_dis_reg, 2'h0,
                      vec_sel_reg, vec_chg_reg} & `PMC_CORE_MASK;

  // Registered read data; unmapped addresses read zero.
  always @(posedge sys_clk) begin
    if (!resetn) begin
      bus_rdata <= 8'h00;
    end else if (clk_en) begin
      if (bus_rd && sel_sleep) begin
        bus_rdata <= sleep_ctrl_reg;
      end else if (bus_rd && sel_core) begin
        bus_rdata <= core_view;
      end else if (bus_rd && sel_prr) begin
        bus_rdata <= prr_reg;
      end else begin
        bus_rdata <= 8'h00;
      end
    end
  end
endmodule

// [pmc_power_control_properties.sv]
`timescale 1ns/100ps
`include "pmc_regs.vh"
// Watches the power control ports and flags timing or value slips.
module pmc_power_control_props #(
  parameter PINS   = 32,
  parameter BOOT_W = 2,
  parameter VEC_W  = 16
) (
  input wire             sys_clk,
  input wire             resetn,
  input wire             clk_en,
  input wire [7:0]       bus_addr,
  input wire             bus_io_space,
  input wire             bus_wr,
  input wire             bus_rd,
  input wire [7:0]       bus_wdata,
  input wire [7:0]       bus_rdata,
  input wire             bus_hit,
  input wire             sleep_instr,
  input wire             wake_request,
  input wire             core_sleeping,
  input wire             core_resume,
  input wire [2:0]       sleep_mode_select,
  input wire             brownout_off,
  input wire             debug_port_fuse,
  input wire             debug_port_enable,
  input wire             pullup_disable,
  input wire [PINS-1:0]  pullup_request,
  input wire [PINS-1:0]  pullup_enable,
  input wire             vector_select,
  input wire [VEC_W-1:0] vector_base,
  input wire             irq_block,
  input wire             timer2_async_select,
  input wire [7:0]       clock_stop,
  input wire             comparator_mux_ok
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);

  // A data-space write to the core control register that sets the change enable.
  sequence vec_chg_wr;
    clk_en && bus_wr && !bus_io_space && bus_addr == `PMC_CORE_ADDR && bus_wdata[0];
  endsequence

  // A wake-up seen while asleep in one of the two standby modes.
  sequence standby_wake;
    clk_en && core_sleeping && wake_request && sleep_mode_select[2:1] == 2'h3;
  endsequence

  read_idle_a: assert property (
    clk_en && !bus_rd |=> bus_rdata == 8'h00) else $error("read data not cleared");
  unmapped_read_a: assert property (
    clk_en && bus_rd && !bus_hit |=> bus_rdata == 8'h00) else $error("unmapped read not zero");
  io_alias_a: assert property (
    bus_io_space && (bus_addr == 8'h33 || bus_addr == 8'h35) |-> bus_hit)
    else $error("I/O alias missed");
  pullup_gate_a: assert property (
    pullup_enable == (pullup_disable ? {PINS{1'b0}} : pullup_request))
    else $error("pull-up enable mismatch");
  debug_fuse_a: assert property (
    !debug_port_fuse [*3] |-> !debug_port_enable) else $error("debug port on without fuse");
  timer2_async_a: assert property (
    timer2_async_select [*3] |-> !clock_stop[6]) else $error("async timer gated");
  comparator_mux_a: assert property (
    comparator_mux_ok == !clock_stop[0]) else $error("comparator mux flag wrong");
  vector_irq_a: assert property (
    vec_chg_wr |=> irq_block) else $error("interrupts not blocked");
  sleep_cause_a: assert property (
    $rose(core_sleeping) |-> $past(sleep_instr)) else $error("sleep without instruction");
  bod_off_cause_a: assert property (
    $rose(brownout_off) |-> $past(sleep_instr)) else $error("detector off without sleep");
  standby_resume_a: assert property (
    standby_wake |-> ##[1:8] core_resume) else $error("standby resume late");
  vector_base_a: assert property (
    !vector_select |-> vector_base == {VEC_W{1'b0}}) else $error("vector base not zero");
endmodule

bind pmc_power_control pmc_power_control_props #(.PINS(PINS), .BOOT_W(BOOT_W), .VEC_W(VEC_W))
  u_pmc_power_control_props (.sys_clk(sys_clk), .resetn(resetn), .clk_en(clk_en),
  .bus_addr(bus_addr), .bus_io_space(bus_io_space), .bus_wr(bus_wr), .bus_rd(bus_rd),
  .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_hit(bus_hit),
  .sleep_instr(sleep_instr), .wake_request(wake_request), .core_sleeping(core_sleeping),
  .core_resume(core_resume), .sleep_mode_select(sleep_mode_select),
  .brownout_off(brownout_off), .debug_port_fuse(debug_port_fuse),
  .debug_port_enable(debug_port_enable), .pullup_disable(pullup_disable),
  .pullup_request(pullup_request), .pullup_enable(pullup_enable),
  .vector_select(vector_select), .vector_base(vector_base), .irq_block(irq_block),
  .timer2_async_select(timer2_async_select), .clock_stop(clock_stop),
  .comparator_mux_ok(comparator_mux_ok));

// [pmc_power_control_test.sv]
`timescale 1ns/100ps
`include "pmc_regs.vh"
module pmc_power_control_test;
  reg         sys_clk = 1'b0;
  reg         resetn = 1'b0;
  reg         clk_en = 1'b1;
  reg  [7:0]  bus_addr = 8'h00;
  reg         bus_io_space = 1'b0;
  reg         bus_wr = 1'b0;
  reg         bus_rd = 1'b0;
  reg  [7:0]  bus_wdata = 8'h00;
  reg         sleep_instr = 1'b0;
  reg         wake_request = 1'b0;
  reg         debug_port_fuse = 1'b1;
  reg  [31:0] pullup_request = 32'h0;
  reg  [1:0]  boot_size_fuse = 2'h0;
  reg         exec_in_boot = 1'b0;
  reg         app_lock = 1'b0;
  reg         boot_lock = 1'b0;
  reg         t2_async = 1'b0;
  wire [7:0]  bus_rdata;
  wire [2:0]  sleep_mode_select;
  wire [31:0] pullup_enable;
  wire [15:0] vector_base;
  wire [7:0]  clock_stop;
  wire        bus_hit, core_sleeping, core_resume, brownout_off, debug_port_enable;
  wire        pullup_disable, vector_select, irq_block, comparator_mux_ok;
  reg  [7:0]  r, prr_m;
  reg         dbg_m, pull_dis_m, vec_sel_m;
  integer     i, n_fail = 0, checked = 0, cyc = 0;

  pmc_power_control u_pmc_power_control (.sys_clk(sys_clk), .resetn(resetn),
    .clk_en(clk_en), .bus_addr(bus_addr), .bus_io_space(bus_io_space), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_hit(bus_hit),
    .sleep_instr(sleep_instr), .wake_request(wake_request), .core_sleeping(core_sleeping),
    .core_resume(core_resume), .sleep_mode_select(sleep_mode_select),
    .brownout_off(brownout_off), .debug_port_fuse(debug_port_fuse),
    .debug_port_enable(debug_port_enable), .pullup_disable(pullup_disable),
    .pullup_request(pullup_request), .pullup_enable(pullup_enable),
    .vector_select(vector_select), .boot_size_fuse(boot_size_fuse),
    .vector_base(vector_base), .exec_in_boot(exec_in_boot),
    .app_section_lock_bit(app_lock), .boot_section_lock_bit(boot_lock),
    .irq_block(irq_block), .timer2_async_select(t2_async), .clock_stop(clock_stop),
    .comparator_mux_ok(comparator_mux_ok));

  // Free-running clock and a hang guard.
  always #50 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      n_fail = n_fail + 1;
      stop_test;
    end
  end

  task stop_test;
    begin
      $display("checked=%0d n_fail=%0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
        $display("STATUS OK");
      end else begin
        $display("STATUS NOT OK");
      end
      $finish;
    end
  endtask

  task chk(input [31:0] got, input [31:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask

  task tick(input integer n);
    begin
      repeat (n) @(posedge sys_clk);
      #1;
    end
  endtask

  // Presents one bus cycle; signals change 1 ns after an edge and hold for one edge.
  task put(input w, input rd, input [7:0] a, input io, input [7:0] d);
    begin
      bus_wr = w;
      bus_rd = rd;
      bus_addr = a;
      bus_io_space = io;
      bus_wdata = d;
      tick(1);
    end
  endtask

  task wr(input [7:0] a, input io, input [7:0] d);
    begin
      put(1'b1, 1'b0, a, io, d);
      put(1'b0, 1'b0, a, io, d);
    end
  endtask

  task rd(input [7:0] a, input io, input [7:0] exp);
    begin
      put(1'b0, 1'b1, a, io, 8'h00);
      chk(bus_rdata, exp);
      put(1'b0, 1'b0, a, io, 8'h00);
    end
  endtask

  task pulse_sleep;
    begin
      sleep_instr = 1'b1;
      tick(1);
      sleep_instr = 1'b0;
    end
  endtask

  task pulse_wake;
    begin
      wake_request = 1'b1;
      tick(1);
      wake_request = 1'b0;
    end
  endtask

  // Main sequence: the model state lives in prr_m; dbg_m, pull_dis_m and vec_sel_m are only cleared.
  initial begin
    r = $urandom(58);
    {dbg_m, pull_dis_m, vec_sel_m} = 3'h0;
    tick(4);
    resetn = 1'b1;
    rd(8'h53, 1'b0, 8'h00);
    rd(8'h35, 1'b1, 8'h00);
    rd(8'h64, 1'b0, 8'h00);
    rd(8'h54, 1'b0, 8'h00);
    for (i = 0; i < 8; i = i + 1) begin
      r = $urandom;
      wr(i[0] ? 8'h33 : 8'h53, i[0], {r[7:4], i[2:0], r[0]});
      rd(8'h53, 1'b0, {4'h0, i[2:0], r[0]});
      chk(sleep_mode_select, i[2:0]);
    end
    prr_m = $urandom;
    wr(8'h64, 1'b0, prr_m);
    wr(8'h44, 1'b1, ~prr_m);
    clk_en = 1'b0;
    wr(8'h64, 1'b0, ~prr_m);
    clk_en = 1'b1;
    rd(8'h64, 1'b0, prr_m);
    rd(8'h44, 1'b1, 8'h00);
    chk(clock_stop, prr_m);
    chk(comparator_mux_ok, !prr_m[0]);
    prr_m = prr_m | 8'h40;
    wr(8'h64, 1'b0, prr_m);
    t2_async = 1'b1;
    tick(3);
    chk(clock_stop, prr_m & 8'hBF);
    t2_async = 1'b0;
    wr(8'h64, 1'b0, 8'h00);
    chk(clock_stop, 8'h00);
    pullup_request = $urandom;
    wr(8'h35, 1'b1, 8'h10);
    chk(pullup_enable, 32'h0);
    rd(8'h55, 1'b0, 8'h10);
    wr(8'h35, 1'b1, 8'h00);
    chk(pullup_enable, pullup_request);
    boot_size_fuse = $urandom;
    wr(8'h55, 1'b0, 8'h02);
    chk(vector_select, 1'b0);
    put(1'b1, 1'b0, 8'h55, 1'b0, 8'h01);
    chk(irq_block, 1'b1);
    put(1'b1, 1'b0, 8'h55, 1'b0, 8'h02);
    put(1'b0, 1'b0, 8'h55, 1'b0, 8'h00);
    chk(vector_select, 1'b1);
    chk(vector_base, (32'hFFFF << (12 + boot_size_fuse)) & 32'hFFFF);
    app_lock = 1'b1;
    tick(6);
    chk(irq_block, 1'b1);
    exec_in_boot = 1'b1;
    tick(1);
    chk(irq_block, 1'b0);
    app_lock = 1'b0;
    wr(8'h55, 1'b0, 8'h01);
    tick(6);
    rd(8'h55, 1'b0, 8'h02);
    chk(irq_block, 1'b0);
    wr(8'h53, 1'b0, 8'h05);
    put(1'b1, 1'b0, 8'h55, 1'b0, 8'h62);
    put(1'b1, 1'b0, 8'h55, 1'b0, 8'h42);
    put(1'b0, 1'b0, 8'h55, 1'b0, 8'h00);
    tick(3);
    pulse_sleep;
    chk(core_sleeping, 1'b1);
    chk(brownout_off, 1'b1);
    pulse_wake;
    tick(1);
    chk(core_sleeping, 1'b0);
    pulse_sleep;
    chk(brownout_off, 1'b0);
    pulse_wake;
    wr(8'h53, 1'b0, 8'h04);
    pulse_sleep;
    chk(core_sleeping, 1'b0);
    wr(8'h33, 1'b1, 8'h0D);
    pulse_sleep;
    pulse_wake;
    tick(3);
    chk(core_sleeping, 1'b1);
    tick(6);
    chk(core_sleeping, 1'b0);
    wr(8'h55, 1'b0, 8'h82);
    tick(6);
    rd(8'h55, 1'b0, 8'h02);
    chk(debug_port_enable, 1'b1);
    put(1'b1, 1'b0, 8'h55, 1'b0, 8'h82);
    put(1'b1, 1'b0, 8'h55, 1'b0, 8'h82);
    put(1'b0, 1'b0, 8'h55, 1'b0, 8'h00);
    rd(8'h55, 1'b0, 8'h82);
    chk(debug_port_enable, 1'b0);
    wr(8'h55, 1'b0, 8'h02);
    tick(6);
    wr(8'h55, 1'b0, 8'h02);
    tick(6);
    rd(8'h55, 1'b0, 8'h82);
    debug_port_fuse = 1'b0;
    tick(4);
    chk(debug_port_enable, 1'b0);
    stop_test;
  end
endmodule
